// ===== irq_events_consts.vh
// constants for the mac interrupt event block: register offsets, field positions,
// reset values and widths; included by the block, its checker and its bench, not by the host model
`ifndef IRQ_EVENTS_CONSTS_VH
`define IRQ_EVENTS_CONSTS_VH

// channel counts and widths
`define NUM_CHAN          8
`define CHAN_BITS         3
`define DESC_ADDR_W       32
`define FREE_COUNT_W      16
`define NUM_STAT_COUNTERS 36
`define TX_ERR_CAUSES     6
`define RX_ERR_CAUSES     2

// register byte offsets (12-bit decode)
`define OFS_RX_IRQ_RAW        12'h000
`define OFS_RX_IRQ_MASKED     12'h004
`define OFS_RX_IRQ_EN_SET     12'h008
`define OFS_RX_IRQ_EN_CLEAR   12'h00c
`define OFS_TX_IRQ_RAW        12'h010
`define OFS_TX_IRQ_MASKED     12'h014
`define OFS_TX_IRQ_EN_SET     12'h018
`define OFS_TX_IRQ_EN_CLEAR   12'h01c
`define OFS_MAC_IRQ_RAW       12'h020
`define OFS_MAC_IRQ_MASKED    12'h024
`define OFS_MAC_IRQ_EN_SET    12'h028
`define OFS_MAC_IRQ_EN_CLEAR  12'h02c
`define OFS_DESC_ERR_CAUSE    12'h030
`define OFS_TX_CP_BASE        12'h040
`define OFS_RX_CP_BASE        12'h060
`define CP_BLOCK_MASK         12'hfe0

// field positions in the rx words: completion in 7:0, low-buffer in 15:8
`define RX_DONE_LSB           0
`define RX_LOW_LSB            8
// field positions in the mac words
`define MAC_COUNTER_BIT       0
`define MAC_DESC_ERR_BIT      1
// field positions in the descriptor error cause word
`define CAUSE_TX_LSB          0
`define CAUSE_RX_LSB          8

// reset values
`define RST_MASK8             8'h00
`define RST_MASK2             2'h0
`define RST_PTR               32'h0000_0000
`define RST_WORD              32'h0000_0000

`endif

// ===== mac_irq_events.v
// interrupt event generation for a multi-channel ethernet mac: per-channel rx
// low-buffer, rx completion and tx completion events, counter overflow and
// descriptor error events, with enable set/clear and raw/masked status.
// assumes an apb master on CLK, dma engines that pulse completion stores and
// error causes, and statistics counters that report their top bits.
`timescale 1ns/100ps
`default_nettype none
`include "irq_events_consts.vh"

module mac_irq_events (
  input  wire                                      CLK,
  input  wire                                      RSTN,
  // apb slave
  input  wire                                      PSEL,
  input  wire                                      PENABLE,
  input  wire                                      PWRITE,
  input  wire [11:0]                               PADDR,
  input  wire [31:0]                               PWDATA,
  output reg  [31:0]                               PRDATA,
  output reg                                       PREADY,
  output reg                                       PSLVERR,
  // flow-control quantities, channel n in bits [16n+15:16n]
  input  wire [`NUM_CHAN*`FREE_COUNT_W-1:0]        RX_FREE_BUFFER_COUNT,
  input  wire [`NUM_CHAN*`FREE_COUNT_W-1:0]        RX_FLOW_THRESHOLD,
  // dma completion pointer stores
  input  wire                                      TX_CP_STORE,
  input  wire [`CHAN_BITS-1:0]                     TX_CP_CHAN,
  input  wire [`DESC_ADDR_W-1:0]                   TX_CP_DATA,
  input  wire                                      RX_CP_STORE,
  input  wire [`CHAN_BITS-1:0]                     RX_CP_CHAN,
  input  wire [`DESC_ADDR_W-1:0]                   RX_CP_DATA,
  // descriptor error cause pulses
  input  wire [`TX_ERR_CAUSES-1:0]                 TX_DESC_ERROR,
  input  wire [`RX_ERR_CAUSES-1:0]                 RX_DESC_ERROR,
  // statistics counter top bits, and management events
  input  wire [`NUM_STAT_COUNTERS-1:0]             STAT_COUNTER_MSB,
  input  wire                                      MGMT_ACCESS_DONE_IRQ,
  input  wire                                      MGMT_LINK_CHANGE_IRQ,
  // shared compare result for flow control
  output reg  [`NUM_CHAN-1:0]                      RX_LOW_BUFFER_PENDING,
  // four interrupt lines to the cpu
  output reg                                       RX_LOW_BUFFER_IRQ,
  output reg                                       RX_DONE_IRQ,
  output reg                                       TX_DONE_IRQ,
  output reg                                       MISC_IRQ
);

  // low-buffer compare of one channel, also used by flow control
  function cmp_low;
    input [`NUM_CHAN*`FREE_COUNT_W-1:0] free_v;
    input [`NUM_CHAN*`FREE_COUNT_W-1:0] thr_v;
    input integer                       ch;
    begin
      cmp_low = (free_v[ch*`FREE_COUNT_W +: `FREE_COUNT_W]
                 <= thr_v[ch*`FREE_COUNT_W +: `FREE_COUNT_W]);
    end
  endfunction

  // channel decode of a completion pointer offset, used for tx and rx
  function [`CHAN_BITS-1:0] cp_chan;
    input [11:0] addr;
    begin
      cp_chan = addr[`CHAN_BITS+1:2];
    end
  endfunction

  // enable masks
  reg  [`NUM_CHAN-1:0]    rx_low_en_q;
  reg  [`NUM_CHAN-1:0]    rx_done_en_q;
  reg  [`NUM_CHAN-1:0]    tx_done_en_q;
  reg  [1:0]              mac_en_q;
  // pending state
  reg  [`NUM_CHAN-1:0]    tx_pend_q;
  reg  [`NUM_CHAN-1:0]    tx_pend_d;
  reg  [`NUM_CHAN-1:0]    rx_pend_q;
  reg  [`NUM_CHAN-1:0]    rx_pend_d;
  reg                     desc_err_q;
  reg  [`TX_ERR_CAUSES-1:0] tx_cause_q;
  reg  [`RX_ERR_CAUSES-1:0] rx_cause_q;
  // completion pointer state memory
  reg  [`DESC_ADDR_W-1:0] tx_cp_mem [0:`NUM_CHAN-1];
  reg  [`DESC_ADDR_W-1:0] rx_cp_mem [0:`NUM_CHAN-1];
  // bus state
  reg  [31:0]             rdata_d;
  reg                     unmapped_d;
  reg  [`NUM_CHAN-1:0]    low_raw;
  wire                    counter_raw;
  wire [1:0]              mac_raw;
  wire                    access;
  wire                    wr_commit;
  wire                    in_tx_cp;
  wire                    in_rx_cp;
  integer                 i;
  // separate loop index for the reset loop, so no variable has two driving processes
  integer                 j;

  // first access cycle loads data and raises pready, second commits the transfer
  assign access    = PSEL & PENABLE & ~PREADY;
  assign wr_commit = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;
  assign in_tx_cp  = ((PADDR & `CP_BLOCK_MASK) == `OFS_TX_CP_BASE) & (PADDR[1:0] == 2'h0);
  assign in_rx_cp  = ((PADDR & `CP_BLOCK_MASK) == `OFS_RX_CP_BASE) & (PADDR[1:0] == 2'h0);

  // raw low-buffer compare, same logic that flow control consumes
  always @* begin
    for (i = 0; i < `NUM_CHAN; i = i + 1) begin
      low_raw[i] = cmp_low(RX_FREE_BUFFER_COUNT, RX_FLOW_THRESHOLD, i);
    end
  end

  // counter overflow follows the top bits live, so it drops once software decrements
  assign counter_raw = |STAT_COUNTER_MSB;
  assign mac_raw     = {desc_err_q, counter_raw};

  // read mux and address check
  always @* begin
    rdata_d    = `RST_WORD;
    unmapped_d = 1'b0;
    if (in_tx_cp) begin
      rdata_d = tx_cp_mem[cp_chan(PADDR)];
    end else if (in_rx_cp) begin
      rdata_d = rx_cp_mem[cp_chan(PADDR)];
    end else begin
      case (PADDR)
        `OFS_RX_IRQ_RAW: begin
          rdata_d[`RX_DONE_LSB +: `NUM_CHAN] = rx_pend_q;
          rdata_d[`RX_LOW_LSB +: `NUM_CHAN]  = low_raw;
        end
        `OFS_RX_IRQ_MASKED: begin
          rdata_d[`RX_DONE_LSB +: `NUM_CHAN] = rx_pend_q & rx_done_en_q;
          rdata_d[`RX_LOW_LSB +: `NUM_CHAN]  = low_raw & rx_low_en_q;
        end
        `OFS_RX_IRQ_EN_SET, `OFS_RX_IRQ_EN_CLEAR: begin
          rdata_d[`RX_DONE_LSB +: `NUM_CHAN] = rx_done_en_q;
          rdata_d[`RX_LOW_LSB +: `NUM_CHAN]  = rx_low_en_q;
        end
        `OFS_TX_IRQ_RAW: begin
          rdata_d[`NUM_CHAN-1:0] = tx_pend_q;
        end
        `OFS_TX_IRQ_MASKED: begin
          rdata_d[`NUM_CHAN-1:0] = tx_pend_q & tx_done_en_q;
        end
        `OFS_TX_IRQ_EN_SET, `OFS_TX_IRQ_EN_CLEAR: begin
          rdata_d[`NUM_CHAN-1:0] = tx_done_en_q;
        end
        `OFS_MAC_IRQ_RAW: begin
          rdata_d[1:0] = mac_raw;
        end
        `OFS_MAC_IRQ_MASKED: begin
          rdata_d[1:0] = mac_raw & mac_en_q;
        end
        `OFS_MAC_IRQ_EN_SET, `OFS_MAC_IRQ_EN_CLEAR: begin
          rdata_d[1:0] = mac_en_q;
        end
        `OFS_DESC_ERR_CAUSE: begin
          rdata_d[`CAUSE_TX_LSB +: `TX_ERR_CAUSES] = tx_cause_q;
          rdata_d[`CAUSE_RX_LSB +: `RX_ERR_CAUSES] = rx_cause_q;
        end
        default: begin
          unmapped_d = 1'b1;
        end
      endcase
    end
  end

  // apb handshake: one wait state, outputs straight from flops
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PREADY  <= 1'b0;
      PRDATA  <= `RST_WORD;
      PSLVERR <= 1'b0;
    end else if (access) begin
      PREADY  <= 1'b1;
      PRDATA  <= PWRITE ? `RST_WORD : rdata_d;
      PSLVERR <= unmapped_d;
    end else begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // enable masks: set register ors ones in, clear register knocks ones out
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_low_en_q  <= `RST_MASK8;
      rx_done_en_q <= `RST_MASK8;
      tx_done_en_q <= `RST_MASK8;
      mac_en_q     <= `RST_MASK2;
    end else if (wr_commit) begin
      case (PADDR)
        `OFS_RX_IRQ_EN_SET: begin
          rx_done_en_q <= rx_done_en_q | PWDATA[`RX_DONE_LSB +: `NUM_CHAN];
          rx_low_en_q  <= rx_low_en_q | PWDATA[`RX_LOW_LSB +: `NUM_CHAN];
        end
        `OFS_RX_IRQ_EN_CLEAR: begin
          rx_done_en_q <= rx_done_en_q & ~PWDATA[`RX_DONE_LSB +: `NUM_CHAN];
          rx_low_en_q  <= rx_low_en_q & ~PWDATA[`RX_LOW_LSB +: `NUM_CHAN];
        end
        `OFS_TX_IRQ_EN_SET: begin
          tx_done_en_q <= tx_done_en_q | PWDATA[`NUM_CHAN-1:0];
        end
        `OFS_TX_IRQ_EN_CLEAR: begin
          tx_done_en_q <= tx_done_en_q & ~PWDATA[`NUM_CHAN-1:0];
        end
        `OFS_MAC_IRQ_EN_SET: begin
          mac_en_q <= mac_en_q | PWDATA[1:0];
        end
        `OFS_MAC_IRQ_EN_CLEAR: begin
          mac_en_q <= mac_en_q & ~PWDATA[1:0];
        end
        default: begin
          mac_en_q <= mac_en_q;
        end
      endcase
    end
  end

  // completion pending: host ack clears on a match, a dma store in the same
  // cycle wins so a freshly finished packet is never lost
  always @* begin
    tx_pend_d = tx_pend_q;
    rx_pend_d = rx_pend_q;
    if (wr_commit && in_tx_cp &&
        PWDATA == tx_cp_mem[cp_chan(PADDR)]) begin
      tx_pend_d[cp_chan(PADDR)] = 1'b0;
    end
    if (wr_commit && in_rx_cp &&
        PWDATA == rx_cp_mem[cp_chan(PADDR)]) begin
      rx_pend_d[cp_chan(PADDR)] = 1'b0;
    end
    if (TX_CP_STORE) begin
      tx_pend_d[TX_CP_CHAN] = 1'b1;
    end
    if (RX_CP_STORE) begin
      rx_pend_d[RX_CP_CHAN] = 1'b1;
    end
  end

  // pending flags held as levels until acknowledged
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_pend_q <= `RST_MASK8;
      rx_pend_q <= `RST_MASK8;
    end else begin
      tx_pend_q <= tx_pend_d;
      rx_pend_q <= rx_pend_d;
    end
  end

  // state memory: only the dma stores; host writes never land here
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (j = 0; j < `NUM_CHAN; j = j + 1) begin
        tx_cp_mem[j] <= `RST_PTR;
        rx_cp_mem[j] <= `RST_PTR;
      end
    end else begin
      if (TX_CP_STORE) begin
        tx_cp_mem[TX_CP_CHAN] <= TX_CP_DATA;
      end
      if (RX_CP_STORE) begin
        rx_cp_mem[RX_CP_CHAN] <= RX_CP_DATA;
      end
    end
  end

  // descriptor errors are sticky; no register write can clear them
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      desc_err_q <= 1'b0;
      tx_cause_q <= {`TX_ERR_CAUSES{1'b0}};
      rx_cause_q <= {`RX_ERR_CAUSES{1'b0}};
    end else begin
      tx_cause_q <= tx_cause_q | TX_DESC_ERROR;
      rx_cause_q <= rx_cause_q | RX_DESC_ERROR;
      if (|TX_DESC_ERROR || |RX_DESC_ERROR) begin
        desc_err_q <= 1'b1;
      end
    end
  end

  // four interrupt lines and the low-buffer pending vector, registered so they never glitch into the cpu
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RX_LOW_BUFFER_PENDING <= `RST_MASK8;
      RX_LOW_BUFFER_IRQ     <= 1'b0;
      RX_DONE_IRQ           <= 1'b0;
      TX_DONE_IRQ           <= 1'b0;
      MISC_IRQ              <= 1'b0;
    end else begin
      RX_LOW_BUFFER_PENDING <= low_raw;
      RX_LOW_BUFFER_IRQ     <= |(low_raw & rx_low_en_q);
      RX_DONE_IRQ           <= |(rx_pend_q & rx_done_en_q);
      TX_DONE_IRQ           <= |(tx_pend_q & tx_done_en_q);
      MISC_IRQ              <= |(mac_raw & mac_en_q) | MGMT_ACCESS_DONE_IRQ
                               | MGMT_LINK_CHANGE_IRQ;
    end
  end

endmodule // mac_irq_events

`default_nettype wire

// ===== irq_events_chk.sv
// checker for the mac interrupt event block: enable copies follow apb commits
// assumes it is bound to the block and sees only the block's ports
`timescale 1ns/100ps
`default_nettype none
`include "irq_events_consts.vh"
module irq_events_chk (
  input wire logic         CLK,
  input wire logic         RSTN,
  input wire logic         PSEL,
  input wire logic         PENABLE,
  input wire logic         PWRITE,
  input wire logic         PREADY,
  input wire logic [11:0]  PADDR,
  input wire logic [31:0]  PWDATA,
  input wire logic [127:0] RX_FREE_BUFFER_COUNT,
  input wire logic [127:0] RX_FLOW_THRESHOLD,
  input wire logic         TX_CP_STORE,
  input wire logic [2:0]   TX_CP_CHAN,
  input wire logic         RX_CP_STORE,
  input wire logic [2:0]   RX_CP_CHAN,
  input wire logic [5:0]   TX_DESC_ERROR,
  input wire logic [1:0]   RX_DESC_ERROR,
  input wire logic [35:0]  STAT_COUNTER_MSB,
  input wire logic         MGMT_ACCESS_DONE_IRQ,
  input wire logic         MGMT_LINK_CHANGE_IRQ,
  input wire logic [7:0]   RX_LOW_BUFFER_PENDING,
  input wire logic         RX_LOW_BUFFER_IRQ,
  input wire logic         RX_DONE_IRQ,
  input wire logic         TX_DONE_IRQ,
  input wire logic         MISC_IRQ
);
  logic [15:0] rx_en_q;
  logic [7:0]  tx_en_q;
  logic [7:0]  cmp;
  logic [1:0]  mac_en_q;
  wire         wc = PSEL & PENABLE & PREADY & PWRITE;
  // the line is registered from the live compare, not from the registered pending copy
  wire         low_any = |(cmp & rx_en_q[15:8]);
  // enable copies; they change on the same commit edge as the block's own
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      {rx_en_q, tx_en_q, mac_en_q} <= 26'h0;
    end else if (wc) begin
      if (PADDR == `OFS_RX_IRQ_EN_SET) rx_en_q <= rx_en_q | PWDATA[15:0];
      if (PADDR == `OFS_RX_IRQ_EN_CLEAR) rx_en_q <= rx_en_q & ~PWDATA[15:0];
      if (PADDR == `OFS_TX_IRQ_EN_SET) tx_en_q <= tx_en_q | PWDATA[7:0];
      if (PADDR == `OFS_TX_IRQ_EN_CLEAR) tx_en_q <= tx_en_q & ~PWDATA[7:0];
      if (PADDR == `OFS_MAC_IRQ_EN_SET) mac_en_q <= mac_en_q | PWDATA[1:0];
      if (PADDR == `OFS_MAC_IRQ_EN_CLEAR) mac_en_q <= mac_en_q & ~PWDATA[1:0];
    end
  end
  // reference compare of free count against threshold
  always @* begin
    for (int k = 0; k < 8; k++) begin
      cmp[k] = RX_FREE_BUFFER_COUNT[16*k +: 16] <= RX_FLOW_THRESHOLD[16*k +: 16];
    end
  end
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // a mask write in the store cycle may legally cancel the line, so it is excluded
  sequence s_tx_store; TX_CP_STORE && tx_en_q[TX_CP_CHAN] && !wc; endsequence
  sequence s_rx_store; RX_CP_STORE && rx_en_q[RX_CP_CHAN] && !wc; endsequence
  property p_tx_store; s_tx_store |-> ##2 TX_DONE_IRQ; endproperty
  a_tx_store: assert property (p_tx_store) else $error("tx line not raised");
  property p_rx_store; s_rx_store |-> ##2 RX_DONE_IRQ; endproperty
  a_rx_store: assert property (p_rx_store) else $error("rx line not raised");
  property p_tx_hold; $fell(TX_DONE_IRQ) |-> $past(wc, 2); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx line fell on its own");
  property p_rx_hold; $fell(RX_DONE_IRQ) |-> $past(wc, 2); endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx line fell on its own");
  property p_pend; $past(RSTN) |-> RX_LOW_BUFFER_PENDING == $past(cmp); endproperty
  a_pend: assert property (p_pend) else $error("low-buffer compare wrong");
  property p_low; $past(RSTN) |-> RX_LOW_BUFFER_IRQ == $past(low_any); endproperty
  a_low: assert property (p_low) else $error("low-buffer line wrong");
  property p_cnt; (|STAT_COUNTER_MSB) && mac_en_q[0] |=> MISC_IRQ; endproperty
  a_cnt: assert property (p_cnt) else $error("counter line missing");
  property p_err; (|{TX_DESC_ERROR, RX_DESC_ERROR}) && mac_en_q[1] && !wc |-> ##2 MISC_IRQ[*2];
  endproperty
  a_err: assert property (p_err) else $error("descriptor error line missing");
  property p_mgmt; MGMT_ACCESS_DONE_IRQ || MGMT_LINK_CHANGE_IRQ |=> MISC_IRQ; endproperty
  a_mgmt: assert property (p_mgmt) else $error("management event not combined");
endmodule // irq_events_chk
bind mac_irq_events irq_events_chk irq_events_chk_inst (.*);
`default_nettype wire

// ===== host_cpu_model.sv
// host cpu model: apb master for the block's register port
// assumes one clock and a slave that answers with pready
`timescale 1ns/100ps
`default_nettype none
module host_cpu_model (
  input  wire logic        CLK,
  input  wire logic        PREADY,
  input  wire logic        PSLVERR,
  input  wire logic [31:0] PRDATA,
  output var  logic        PSEL,
  output var  logic        PENABLE,
  output var  logic        PWRITE,
  output var  logic [11:0] PADDR,
  output var  logic [31:0] PWDATA
);
  // idle bus at time zero
  initial {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = 47'h0;
  // one transfer; an acknowledge is a plain write of the last pointer processed
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] dd,
                      output logic [31:0] q, output logic e);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= dd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // wait as long as the slave needs; only the bench watchdog ends a hang
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // released lines show the inverse so stale values never look valid
    PADDR <= ~a;
    PWDATA <= ~dd;
  endtask
endmodule // host_cpu_model
`default_nettype wire

// ===== tb_mac_irq_events.sv
// self-checking bench for the mac interrupt event block
// assumes the host model drives apb and the checker is bound to the block
`timescale 1ns/100ps
`default_nettype none
`include "irq_events_consts.vh"
module tb_mac_irq_events;
  logic         CLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, e;
  logic         TX_CP_STORE, RX_CP_STORE, MGMT_ACCESS_DONE_IRQ, MGMT_LINK_CHANGE_IRQ;
  logic         RX_LOW_BUFFER_IRQ, RX_DONE_IRQ, TX_DONE_IRQ, MISC_IRQ;
  logic [2:0]   TX_CP_CHAN, RX_CP_CHAN;
  logic [5:0]   TX_DESC_ERROR;
  logic [1:0]   RX_DESC_ERROR;
  logic [7:0]   RX_LOW_BUFFER_PENDING;
  logic [8:0]   m;
  logic [11:0]  PADDR, pa;
  logic [31:0]  PWDATA, PRDATA, TX_CP_DATA, RX_CP_DATA, q;
  logic [35:0]  STAT_COUNTER_MSB;
  logic [127:0] RX_FREE_BUFFER_COUNT, RX_FLOW_THRESHOLD;
  int           fail_count = 0, n_checks = 0, i;
  // address, word written, word read back, error expected
  logic [76:0]  rows [8] = '{{12'h000, 32'hffff_ffff, 32'h0, 1'b0},
    {12'h014, 32'hffff_ffff, 32'h0, 1'b0}, {12'h020, 32'hffff_ffff, 32'h0, 1'b0},
    {12'h024, 32'hffff_ffff, 32'h0, 1'b0}, {12'h030, 32'hffff_ffff, 32'h0, 1'b0},
    {12'h05c, 32'h1234_5678, 32'h0, 1'b0}, {12'h07c, 32'h1234_5678, 32'h0, 1'b0},
    {12'h034, 32'hffff_ffff, 32'h0, 1'b1}};
  mac_irq_events mac_irq_events_inst (.*);
  host_cpu_model host_cpu_model_inst (.*);
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  // hang guard, far beyond the length of the sequence
  initial begin
    #200000;
    fail_count++;
    close_out;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chb(input logic g, input logic x);
    chk({31'h0, g}, {31'h0, x});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] dd);
    host_cpu_model_inst.xfer(1'b1, a, dd, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic ee);
    host_cpu_model_inst.xfer(1'b0, a, 32'h0, q, e);
    chk(q, x);
    chb(e, ee);
  endtask
  task automatic settle;
    repeat (2) @(posedge CLK);
    #1;
  endtask
  // dma store: tx uses channel 1, rx channel 2
  task automatic store(input int dd, input logic [31:0] v);
    @(posedge CLK);
    if (dd) {RX_CP_STORE, RX_CP_CHAN, RX_CP_DATA} <= {1'b1, 3'h2, v};
    else {TX_CP_STORE, TX_CP_CHAN, TX_CP_DATA} <= {1'b1, 3'h1, v};
    @(posedge CLK);
    {TX_CP_STORE, RX_CP_STORE} <= 2'h0;
  endtask
  task close_out;
    if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    RSTN = 1'b0;
    {TX_CP_STORE, RX_CP_STORE, MGMT_ACCESS_DONE_IRQ, MGMT_LINK_CHANGE_IRQ} = 4'h0;
    {TX_CP_CHAN, RX_CP_CHAN, TX_CP_DATA, RX_CP_DATA} = 70'h0;
    {TX_DESC_ERROR, RX_DESC_ERROR, STAT_COUNTER_MSB} = 44'h0;
    RX_FREE_BUFFER_COUNT = {8{16'hffff}};
    RX_FLOW_THRESHOLD = 128'h0;
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    for (i = 0; i < 8; i++) begin
      wr(rows[i][76:65], rows[i][64:33]);
      chb(e, rows[i][0]);
      rd(rows[i][76:65], rows[i][32:1], rows[i][0]);
    end
    wr(`OFS_RX_IRQ_EN_SET, 32'h0000_a5a5);
    wr(`OFS_RX_IRQ_EN_CLEAR, 32'h0000_0101);
    rd(`OFS_RX_IRQ_EN_SET, 32'h0000_a4a4, 1'b0);
    rd(`OFS_RX_IRQ_EN_CLEAR, 32'h0000_a4a4, 1'b0);
    wr(`OFS_TX_IRQ_EN_SET, 32'h0000_000f);
    wr(`OFS_TX_IRQ_EN_CLEAR, 32'h0000_0001);
    rd(`OFS_TX_IRQ_EN_CLEAR, 32'h0000_000e, 1'b0);
    wr(`OFS_MAC_IRQ_EN_SET, 32'h0000_0003);
    rd(`OFS_MAC_IRQ_EN_SET, 32'h0000_0003, 1'b0);
    // channel 2 exactly at threshold, channel 3 one above it
    @(posedge CLK);
    RX_FREE_BUFFER_COUNT[63:32] <= {16'h0006, 16'h0005};
    RX_FLOW_THRESHOLD[63:32] <= {16'h0005, 16'h0005};
    settle;
    chk({24'h0, RX_LOW_BUFFER_PENDING}, 32'h0000_0004);
    chb(RX_LOW_BUFFER_IRQ, 1'b1);
    rd(`OFS_RX_IRQ_MASKED, 32'h0000_0400, 1'b0);
    wr(`OFS_RX_IRQ_EN_CLEAR, 32'h0000_0400);
    settle;
    chb(RX_LOW_BUFFER_IRQ, 1'b0);
    rd(`OFS_RX_IRQ_RAW, 32'h0000_0400, 1'b0);
    RX_FREE_BUFFER_COUNT <= {8{16'hffff}};
    // two stores, a stale acknowledge, then the matching one
    for (i = 0; i < 2; i++) begin
      pa = i ? 12'h068 : 12'h044;
      store(i, 32'h0000_1000);
      store(i, 32'h0000_2000);
      settle;
      chb(i ? RX_DONE_IRQ : TX_DONE_IRQ, 1'b1);
      wr(pa, 32'h0000_1000);
      settle;
      chb(i ? RX_DONE_IRQ : TX_DONE_IRQ, 1'b1);
      rd(pa, 32'h0000_2000, 1'b0);
      wr(pa, 32'h0000_2000);
      settle;
      chb(i ? RX_DONE_IRQ : TX_DONE_IRQ, 1'b0);
      rd(i ? `OFS_RX_IRQ_RAW : `OFS_TX_IRQ_RAW, 32'h0, 1'b0);
    end
    STAT_COUNTER_MSB <= 36'h8_0000_0000;
    settle;
    chb(MISC_IRQ, 1'b1);
    rd(`OFS_MAC_IRQ_RAW, 32'h0000_0001, 1'b0);
    STAT_COUNTER_MSB <= 36'h0;
    settle;
    chb(MISC_IRQ, 1'b0);
    // every descriptor error cause, one at a time
    for (i = 0; i < 8; i++) begin
      @(posedge CLK);
      {RX_DESC_ERROR, TX_DESC_ERROR} <= 8'h01 << i;
      @(posedge CLK);
      {RX_DESC_ERROR, TX_DESC_ERROR} <= 8'h00;
      m = (9'h001 << (i + 1)) - 9'h001;
      rd(`OFS_DESC_ERR_CAUSE, {22'h0, m[7:6], 2'h0, m[5:0]}, 1'b0);
    end
    chb(MISC_IRQ, 1'b1);
    wr(`OFS_MAC_IRQ_EN_CLEAR, 32'h0000_0002);
    settle;
    chb(MISC_IRQ, 1'b0);
    rd(`OFS_MAC_IRQ_RAW, 32'h0000_0002, 1'b0);
    for (i = 0; i < 2; i++) begin
      {MGMT_ACCESS_DONE_IRQ, MGMT_LINK_CHANGE_IRQ} <= i ? 2'h1 : 2'h2;
      settle;
      chb(MISC_IRQ, 1'b1);
      {MGMT_ACCESS_DONE_IRQ, MGMT_LINK_CHANGE_IRQ} <= 2'h0;
      // let the drop reach the line before the next event is driven
      settle;
      chb(MISC_IRQ, 1'b0);
    end
    @(posedge CLK);
    RSTN <= 1'b0;
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    rd(`OFS_DESC_ERR_CAUSE, 32'h0, 1'b0);
    rd(`OFS_MAC_IRQ_EN_SET, 32'h0, 1'b0);
    close_out;
  end
endmodule // tb_mac_irq_events
`default_nettype wire
